// ---- rtl/pwrilk_top.sv ----
// Power-stage interlock: arms PWM, times settling, handles trips.
// Assumes Avalon-MM master, asynchronous trip inputs from pins.
`timescale 1ns/1ps
module pwrilk_top
    import pwrilk_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Interlock pins
    input wire logic arm_in,
    input wire logic trip_zone_in_1,
    input wire logic trip_zone_in_2,
    input wire logic trip_zone_in_3,
    input wire logic [2:0] analog_trip,
    input wire logic pwm_underflow,
    // PWM gating
    input wire logic [7:0] pwm_in,
    input wire logic [7:0] pwm_passive,
    output logic [7:0] pwm_out,
    output logic [7:0] pwm_oe,
    // Status pins
    output logic ready_out,
    output logic stage_en_out,
    output logic stage_en_oe,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [12:0] ctrl_ff;
    logic [EV_W-1:0] irq_ff;
    logic [EV_W-1:0] mask_ff;
    logic [EV_W-1:0] ev;
    logic rd_ack_ff;
    logic [5:0] sync_q;
    logic arm_s;
    logic arm_prev_ff;
    logic arm_rise;
    logic [2:0] tz_trip;
    logic [2:0] tz_osht;
    logic [2:0] tz_cbc;
    logic [2:0] an_osht;
    logic osht_ff;
    logic cbc_ff;
    logic cbc_prev_ff;
    logic [CNT_W-1:0] cnt_ff;
    pwrilk_state_t state_ff;
    pwrilk_state_t nxt_state;
    logic pwm_live;
    logic tripped;

    // Reaction of one trip zone
    function automatic logic [1:0] zone_mode(input logic [12:0] c,
                                             input int pos);
        zone_mode = {c[pos+1], c[pos]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // synchronise external inputs
    pwrilk_sync #(.W(6), .INIT(6'h07)) u_sync (
        .clock(clock),
        .rst(rst),
        .d({analog_trip[2], analog_trip[1], analog_trip[0],
            trip_zone_in_3, trip_zone_in_2, trip_zone_in_1}),
        .q(sync_q)
    );
    // Arm input synchroniser held apart, reset low
    logic [1:0] arm_sync_ff;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arm_sync_ff <= 2'h0;
        end else begin
            arm_sync_ff <= {arm_sync_ff[0], arm_in};
        end
    end
    assign arm_s = arm_sync_ff[1];

    // Edge detector on the synchronised arm
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            arm_prev_ff <= 1'b0;
        end else begin
            arm_prev_ff <= arm_s;
        end
    end
    assign arm_rise = arm_s && !arm_prev_ff;

    assign tz_trip = ~sync_q[2:0];

    always_comb begin
        tz_osht[0] = tz_trip[0] && zone_mode(ctrl_ff, CTRL_TZ1) == TZ_OSHT;
        tz_osht[1] = tz_trip[1] && zone_mode(ctrl_ff, CTRL_TZ2) == TZ_OSHT;
        tz_osht[2] = tz_trip[2] && zone_mode(ctrl_ff, CTRL_TZ3) == TZ_OSHT;
        tz_cbc[0] = tz_trip[0] && zone_mode(ctrl_ff, CTRL_TZ1) == TZ_CBC;
        tz_cbc[1] = tz_trip[1] && zone_mode(ctrl_ff, CTRL_TZ2) == TZ_CBC;
        tz_cbc[2] = tz_trip[2] && zone_mode(ctrl_ff, CTRL_TZ3) == TZ_CBC;
    end

    // analog signals A, B, C enable
    assign an_osht = sync_q[5:3] &
        {ctrl_ff[CTRL_TC], ctrl_ff[CTRL_TB], ctrl_ff[CTRL_TA]};

    ////////////////////////////////////////////////////////////////////////
    // Interlock state sequence
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (arm_rise) begin
                    nxt_state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (!arm_s) begin
                    nxt_state = ST_IDLE;
                end else if (cnt_ff == CNT_W'(SETTLE_CYCLES - 1)) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!arm_s) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
        end else if (state_ff == ST_SETTLE) begin
            cnt_ff <= cnt_ff + CNT_W'(1);
        end else begin
            cnt_ff <= '0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osht_ff <= 1'b0;
        end else if ((|tz_osht) || (|an_osht)) begin
            osht_ff <= 1'b1;
        end else if (arm_rise) begin
            osht_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cbc_ff <= 1'b0;
        end else if (|tz_cbc) begin
            cbc_ff <= 1'b1;
        end else if (pwm_underflow) begin
            cbc_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign tripped = osht_ff || cbc_ff;
    assign pwm_live = !ctrl_ff[CTRL_PRESENT] ||
        (state_ff == ST_RUN);

    // PWM output stage
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pwm_out <= 8'h00;
            pwm_oe <= 8'h00;
        end else if (pwm_live && !tripped) begin
            pwm_out <= pwm_in;
            pwm_oe <= 8'hFF;
        end else begin
            pwm_out <= pwm_passive;
            pwm_oe <= ctrl_ff[CTRL_SAFE_FLOAT] ? 8'h00 : 8'hFF;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ready_out <= 1'b0;
        end else begin
            ready_out <= pwm_live;
        end
    end

    // Enable pin: state only, not PWM gating
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stage_en_out <= 1'b0;
            stage_en_oe <= 1'b0;
        end else begin
            stage_en_oe <= ctrl_ff[CTRL_PIN_EN];
            stage_en_out <= (nxt_state != ST_IDLE) ?
                ctrl_ff[CTRL_POL_HIGH] : !ctrl_ff[CTRL_POL_HIGH];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus: reads answer one cycle later, writes at once
    assign waitrequest = read && !rd_ack_ff;

    // Previous cycle trip level for the rise event
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cbc_prev_ff <= 1'b0;
        end else begin
            cbc_prev_ff <= cbc_ff;
        end
    end
    assign ev = {cbc_ff && !cbc_prev_ff,
                 osht_ff, state_ff == ST_RUN, arm_rise};

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_ack_ff <= 1'b0;
            readdata <= 32'h0000_0000;
        end else begin
            rd_ack_ff <= read && !rd_ack_ff;
            if (read && !rd_ack_ff) begin
                case (address)
                    OFS_CTRL: readdata <= {19'h0, ctrl_ff};
                    OFS_STATUS: readdata <= {28'h0, cbc_ff, osht_ff,
                        ready_out, state_ff != ST_IDLE};
                    OFS_IRQ: readdata <= {28'h0, irq_ff};
                    OFS_MASK: readdata <= {28'h0, mask_ff};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control and mask writes
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl_ff <= CTRL_RESET;
            mask_ff <= 4'h0;
        end else if (write) begin
            if (address == OFS_CTRL) begin
                ctrl_ff <= writedata[12:0];
            end
            if (address == OFS_MASK) begin
                mask_ff <= writedata[3:0];
            end
        end
    end

    // Sticky events, write one clears, set wins
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq_ff <= 4'h0;
        end else begin
            irq_ff <= ev | (irq_ff &
                ~((write && address == OFS_IRQ) ? writedata[3:0] : 4'h0));
        end
    end
    assign irq = |(irq_ff & mask_ff);

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_pwm_off_idle: assert property (@(posedge clock) disable iff (rst)
        (ctrl_ff[CTRL_PRESENT] && state_ff == ST_IDLE) |=>
        ready_out == 1'b0)
        else $error("ready while idle");
    a_settle_hold: assert property (@(posedge clock) disable iff (rst)
        (ctrl_ff[CTRL_PRESENT] && state_ff == ST_IDLE &&
        nxt_state == ST_SETTLE) |=>
        !ready_out [*8])
        else $error("ready too early");
    a_ready_pwm: assert property (@(posedge clock) disable iff (rst)
        $rose(ready_out) |-> (pwm_oe == 8'hFF || $past(tripped)))
        else $error("ready without pwm");
    a_en_polarity: assert property (@(posedge clock) disable iff (rst)
        (arm_rise && $stable(ctrl_ff)) |=>
        stage_en_out == ctrl_ff[CTRL_POL_HIGH])
        else $error("enable pin wrong level");
    a_en_none: assert property (@(posedge clock) disable iff (rst)
        (!ctrl_ff[CTRL_PIN_EN] && $stable(ctrl_ff)) |=>
        !stage_en_oe)
        else $error("enable pin driven");
    a_absent_live: assert property (@(posedge clock) disable iff (rst)
        (!ctrl_ff[CTRL_PRESENT] && !tripped) |=>
        pwm_out == $past(pwm_in))
        else $error("pwm gated while absent");
    a_osht_hold: assert property (@(posedge clock) disable iff (rst)
        (osht_ff && !arm_rise) |=> osht_ff)
        else $error("one-shot cleared");
    a_cbc_clear: assert property (@(posedge clock) disable iff (rst)
        (cbc_ff && pwm_underflow && !(|tz_cbc)) |=> !cbc_ff)
        else $error("cycle trip stuck");
    a_float_safe: assert property (@(posedge clock) disable iff (rst)
        (tripped && ctrl_ff[CTRL_SAFE_FLOAT] && $stable(ctrl_ff)) |=>
        pwm_oe == 8'h00)
        else $error("not floating");
    c_ready: cover property (@(posedge clock) $rose(ready_out));
    c_osht: cover property (@(posedge clock) $rose(osht_ff));
    c_cbc: cover property (@(posedge clock) $fell(cbc_ff));
    c_irq: cover property (@(posedge clock) $rose(irq));
endmodule

// ---- rtl/pwrilk_pkg.sv ----
// Package: constants, modes and register map of the power-stage interlock.
// Assumes a 125 MHz system clock and Avalon-MM register access.
package pwrilk_pkg;
    // Clock and timing
    localparam int CLK_HZ = 125_000_000;
    localparam int SETTLE_MS = 100;
    localparam int SETTLE_CYCLES = (CLK_HZ / 1000) * SETTLE_MS;
    localparam int CNT_W = 24;
    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ = 4'h8;
    localparam logic [3:0] OFS_MASK = 4'hC;
    // Control field positions
    localparam int CTRL_PRESENT = 0;
    localparam int CTRL_PIN_EN = 1;
    localparam int CTRL_POL_HIGH = 2;
    localparam int CTRL_SAFE_FLOAT = 3;
    localparam int CTRL_TZ1 = 4;
    localparam int CTRL_TZ2 = 6;
    localparam int CTRL_TZ3 = 8;
    localparam int CTRL_TA = 10;
    localparam int CTRL_TB = 11;
    localparam int CTRL_TC = 12;
    localparam logic [12:0] CTRL_RESET = 13'h0001;
    // Status field positions
    localparam int ST_ARMED = 0;
    localparam int ST_READY = 1;
    localparam int ST_OSHT = 2;
    localparam int ST_CBC = 3;
    // Interrupt event positions
    localparam int EV_ARM = 0;
    localparam int EV_READY = 1;
    localparam int EV_OSHT = 2;
    localparam int EV_CBC = 3;
    localparam int EV_W = 4;
    // Digital trip reactions
    localparam logic [1:0] TZ_NONE = 2'h0;
    localparam logic [1:0] TZ_OSHT = 2'h1;
    localparam logic [1:0] TZ_CBC = 2'h2;
    // Interlock states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SETTLE = 3'b010,
        ST_RUN = 3'b100
    } pwrilk_state_t;
endpackage

// ---- rtl/pwrilk_sync.sv ----
// Two-stage synchroniser for a bundle of level inputs.
// Assumes inputs are stable across two clock edges to count.
`timescale 1ns/1ps
module pwrilk_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;

    // First stage feeds only the second
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            meta_ff <= INIT;
            q <= INIT;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule

// ---- test/pwrilk_pwm_model.sv ----
// Behavioural PWM generator and gate driver side of the interlock.
// Assumes one system clock and an active-high asynchronous reset.
`timescale 1ns/1ps
module pwrilk_pwm_model #(
    parameter int PERIOD = 16,
    parameter logic [7:0] PASSIVE = 8'h0F
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Interlock status
    input wire logic ready_out,
    // PWM generator outputs
    output logic [7:0] pwm_in,
    output logic [7:0] pwm_passive,
    output logic pwm_underflow,
    // Downstream regulator release
    output logic regulator_run
);
    logic [7:0] cnt_ff;

    ////////////////////////////////////////////////////////////////////////
    // Carrier counter, pattern changes every cycle
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_ff <= 8'h00;
        end else if (cnt_ff == 8'(PERIOD - 1)) begin
            cnt_ff <= 8'h00;
        end else begin
            cnt_ff <= cnt_ff + 8'h01;
        end
    end

    // Underflow pulse and waveform
    assign pwm_underflow = (cnt_ff == 8'h00);
    assign pwm_in = {cnt_ff[3:0], ~cnt_ff[3:0]};
    assign pwm_passive = PASSIVE;

    assign regulator_run = ready_out;
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the power-stage interlock top.
// Assumes the PWM model above and a 125 MHz system clock.
`timescale 1ns/1ps
module tb_top
    import pwrilk_pkg::*;
;
    logic clock, rst, read, write, waitrequest, arm_in, pwm_underflow;
    logic ready_out, stage_en_out, stage_en_oe, irq, regulator_run;
    logic [3:0] address;
    logic [31:0] writedata, readdata, rd;
    logic [2:0] trip_zone_in, analog_trip;
    logic [7:0] pwm_in, pwm_passive, pwm_out, pwm_oe, prev_in;
    int err_total, checks_done;

    ////////////////////////////////////////////////////////////////////////
    // Design and far-side model
    pwrilk_top u_dut (.clock(clock), .rst(rst), .address(address),
        .read(read), .write(write), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest), .arm_in(arm_in),
        .trip_zone_in_1(trip_zone_in[0]), .trip_zone_in_2(trip_zone_in[1]),
        .trip_zone_in_3(trip_zone_in[2]), .analog_trip(analog_trip),
        .pwm_underflow(pwm_underflow), .pwm_in(pwm_in),
        .pwm_passive(pwm_passive), .pwm_out(pwm_out), .pwm_oe(pwm_oe),
        .ready_out(ready_out), .stage_en_out(stage_en_out),
        .stage_en_oe(stage_en_oe), .irq(irq));
    pwrilk_pwm_model u_pwm (.clock(clock), .rst(rst),
        .ready_out(ready_out), .pwm_in(pwm_in), .pwm_passive(pwm_passive),
        .pwm_underflow(pwm_underflow), .regulator_run(regulator_run));

    // Clock and last-cycle waveform
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) prev_in <= pwm_in;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // One Avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        @(posedge clock);
        while (waitrequest !== 1'b0) begin
            @(posedge clock);
        end
        rd = readdata;
        write <= 1'b0;
        read <= 1'b0;
    endtask

    // Live gated output or driven passive level
    task automatic chk_out(input logic live);
        @(negedge clock);
        check(32'(pwm_out), live ? 32'(prev_in) : 32'(pwm_passive));
        check(32'(pwm_oe), 32'h0000_00FF);
    endtask

    task automatic set_arm(input logic v);
        @(posedge clock);
        arm_in <= v;
        cyc(6);
    endtask

    task automatic set_trip(input int z, input logic dig, input logic v);
        @(posedge clock);
        if (dig) begin
            trip_zone_in[z] <= ~v;
        end else begin
            analog_trip[z] <= v;
        end
        cyc(6);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_reset();
        @(negedge clock);
        check(32'(stage_en_oe), 32'h0000_0000);
        check(32'(ready_out), 32'h0000_0000);
        chk_out(1'b0);
        bus(1'b0, OFS_CTRL, 32'h0000_0000);
        check(rd, 32'(CTRL_RESET));
        bus(1'b0, 4'h1, 32'h0000_0000);
        check(rd, 32'h0000_0000);
    endtask

    task automatic test_arm();
        bus(1'b1, OFS_MASK, 32'h0000_0000);
        bus(1'b1, OFS_IRQ, 32'h0000_000F);
        bus(1'b1, OFS_CTRL, 32'h0000_0003);
        set_arm(1'b1);
        @(negedge clock);
        check(32'(stage_en_oe), 32'h0000_0001);
        check(32'(stage_en_out), 32'h0000_0000);
        check(32'(ready_out), 32'h0000_0000);
        check(32'(regulator_run), 32'h0000_0000);
        chk_out(1'b0);
        bus(1'b0, OFS_STATUS, 32'h0000_0000);
        check(32'(rd[1:0]), 32'h0000_0001);
        check(32'(irq), 32'h0000_0000);
        bus(1'b1, OFS_MASK, 32'h0000_0001);
        @(negedge clock);
        check(32'(irq), 32'h0000_0001);
        bus(1'b1, OFS_IRQ, 32'h0000_0001);
        @(negedge clock);
        check(32'(irq), 32'h0000_0000);
        bus(1'b1, OFS_MASK, 32'h0000_0000);
        set_arm(1'b0);
        bus(1'b1, OFS_CTRL, 32'h0000_0007);
        set_arm(1'b1);
        @(negedge clock);
        check(32'(stage_en_out), 32'h0000_0001);
        set_arm(1'b0);
    endtask

    task automatic test_absent();
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        cyc(4);
        @(negedge clock);
        check(32'(ready_out), 32'h0000_0001);
        chk_out(1'b1);
    endtask

    task automatic test_digital(input int z);
        bus(1'b1, OFS_CTRL, 32'(TZ_CBC) << (CTRL_TZ1 + 2 * z));
        set_trip(z, 1'b1, 1'b1);
        chk_out(1'b0);
        set_trip(z, 1'b1, 1'b0);
        cyc(34);
        chk_out(1'b1);
        bus(1'b1, OFS_CTRL, 32'(TZ_OSHT) << (CTRL_TZ1 + 2 * z));
        set_trip(z, 1'b1, 1'b1);
        set_trip(z, 1'b1, 1'b0);
        cyc(34);
        chk_out(1'b0);
        set_arm(1'b1);
        set_arm(1'b0);
        chk_out(1'b1);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        set_trip(z, 1'b1, 1'b1);
        chk_out(1'b1);
        set_trip(z, 1'b1, 1'b0);
    endtask

    task automatic test_float();
        bus(1'b1, OFS_CTRL, 32'h0000_0028);
        set_trip(0, 1'b1, 1'b1);
        @(negedge clock);
        check(32'(pwm_oe), 32'h0000_0000);
        set_trip(0, 1'b1, 1'b0);
        cyc(34);
        chk_out(1'b1);
    endtask

    task automatic test_analog(input int s);
        bus(1'b1, OFS_CTRL, 32'h0000_0001 << (CTRL_TA + s));
        set_trip(s, 1'b0, 1'b1);
        chk_out(1'b0);
        set_trip(s, 1'b0, 1'b0);
        cyc(34);
        chk_out(1'b0);
        set_arm(1'b1);
        set_arm(1'b0);
        chk_out(1'b1);
        bus(1'b1, OFS_CTRL, 32'h0000_0000);
        set_trip(s, 1'b0, 1'b1);
        chk_out(1'b1);
        set_trip(s, 1'b0, 1'b0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        cyc(20000);
        err_total++;
        complete_run();
    end

    // Main sequence
    initial begin
        err_total = 0;
        checks_done = 0;
        rst = 1'b1;
        address = 4'h0;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        arm_in = 1'b0;
        trip_zone_in = 3'h7;
        analog_trip = 3'h0;
        cyc(10);
        rst <= 1'b0;
        cyc(2);
        test_reset();
        test_arm();
        test_absent();
        for (int z = 0; z < 3; z++) begin
            test_digital(z);
            test_analog(z);
        end
        test_float();
        complete_run();
    end
endmodule
